// ---- src/bars_alu.sv ----
module bars_alu (
  input  wire logic                          clk,
  input  wire logic                          reset_n,
  input  wire logic                          cmdValid,
  input  wire bars_pkg::bars_cmd_type        cmd,
  output logic                               busy,
  output logic                               done,
  output logic      [bars_pkg::DATA_W-1:0]   acc,
  output bars_pkg::bars_flags_type           flags,
  output logic      [bars_pkg::DATA_W-1:0]   pinDirLo,
  output logic      [bars_pkg::DATA_W-1:0]   pinDirHi,
  output logic      [bars_pkg::DATA_W-1:0]   result
);

  // ****************************************************************
  // State and operands
  // ****************************************************************
  typedef enum logic [1:0] {
    BARS_ST_IDLE  = 2'b00,
    BARS_ST_FETCH = 2'b01,
    BARS_ST_EXEC  = 2'b11
  } bars_state_type;

  bars_state_type                state;
  bars_state_type                next_state;
  bars_pkg::bars_cmd_type        held;
  bars_pkg::bars_cmd_type        next_held;
  logic [bars_pkg::DATA_W-1:0]   next_acc;
  bars_pkg::bars_flags_type      next_flags;
  logic [bars_pkg::DATA_W-1:0]   next_pinDirLo;
  logic [bars_pkg::DATA_W-1:0]   next_pinDirHi;
  logic [bars_pkg::DATA_W-1:0]   next_result;
  logic                          next_busy;
  logic                          next_done;
  logic [bars_pkg::DATA_W-1:0]   regData;
  logic                          wrEn;
  logic [bars_pkg::DATA_W-1:0]   aluOut;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic isZero(input logic [bars_pkg::DATA_W-1:0] v);
    isZero = (v == '0);
  endfunction

  // Two's complement subtraction; the top bit is set when no borrow occurs.
  // Zero-extended nibbles carry out of the top bit exactly when the low
  // nibble does not borrow, so one function serves both carry flags.
  function automatic logic [bars_pkg::DATA_W:0] subtract(input logic [bars_pkg::DATA_W-1:0] minuend,
                                                          input logic [bars_pkg::DATA_W-1:0] subtrahend);
    subtract = {1'b0, minuend} + {1'b0, ~subtrahend} + 9'h001;
  endfunction

  // ****************************************************************
  // File registers
  // ****************************************************************
  // The read address follows next_held, so the operand is already
  // registered by the time the fetch state hands over to execute.
  bars_regfile u_regfile (
    .clk     (clk),
    .reset_n (reset_n),
    .rdAddr  (next_held.addr),
    .rdData  (regData),
    .wrEn    (wrEn),
    .wrAddr  (held.addr),
    .wrData  (aluOut)
  );

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // A command is taken in idle; the register read costs one cycle,
  // so each command finishes two cycles after it is taken.
  always_comb begin
    next_state = state;
    next_held  = held;
    next_busy  = busy;
    next_done  = 1'b0;
    unique case (state)
      BARS_ST_IDLE: begin
        // Commands offered while busy are ignored, never queued.
        if (cmdValid && (cmd.op != bars_pkg::BARS_OP_NONE)) begin
          next_held  = cmd;
          next_state = BARS_ST_FETCH;
          next_busy  = 1'b1;
        end
      end
      BARS_ST_FETCH: begin
        next_state = BARS_ST_EXEC;
      end
      BARS_ST_EXEC: begin
        // A new command may already be offered while done is high.
        next_done  = 1'b1;
        next_busy  = 1'b0;
        next_state = BARS_ST_IDLE;
      end
      default: begin
        // An illegal state code falls back to idle and drops busy.
        next_state = BARS_ST_IDLE;
        next_busy  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= BARS_ST_IDLE;
      held  <= '0;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      state <= next_state;
      held  <= next_held;
      busy  <= next_busy;
      done  <= next_done;
    end
  end

  // ****************************************************************
  // Accumulator, flags and write-back
  // ****************************************************************
  // Everything here moves only in the execute state, so acc and flags
  // stay stable as operands while the register read is in flight.
  always_comb begin
    logic [bars_pkg::DATA_W:0] diff;
    logic [bars_pkg::DATA_W:0] lowDiff;
    diff        = '0;
    lowDiff     = '0;
    next_acc    = acc;
    next_flags  = flags;
    next_result = result;
    wrEn        = 1'b0;
    aluOut      = regData;
    if (state == BARS_ST_EXEC) begin
      unique case (held.op)
        bars_pkg::BARS_OP_RLC: begin
          aluOut           = {regData[6:0], flags.carry};
          next_flags.carry = regData[7];
        end
        bars_pkg::BARS_OP_RRC: begin
          aluOut           = {flags.carry, regData[7:1]};
          next_flags.carry = regData[0];
        end
        bars_pkg::BARS_OP_SUB: begin
          diff                 = subtract(regData, acc);
          lowDiff              = subtract({4'h0, regData[3:0]}, {4'h0, acc[3:0]});
          aluOut               = diff[7:0];
          next_flags.carry     = diff[8];
          next_flags.halfCarry = lowDiff[8];
          next_flags.zero      = isZero(diff[7:0]);
        end
        bars_pkg::BARS_OP_SWAP: begin
          aluOut = {regData[3:0], regData[7:4]};
        end
        bars_pkg::BARS_OP_XORREG: begin
          aluOut          = acc ^ regData;
          next_flags.zero = isZero(acc ^ regData);
        end
        bars_pkg::BARS_OP_XORIMM: begin
          aluOut          = acc ^ held.imm;
          next_flags.zero = isZero(acc ^ held.imm);
        end
        bars_pkg::BARS_OP_NONE, bars_pkg::BARS_OP_DIR: begin
          aluOut = acc;
        end
      endcase
      // Immediate XOR and direction loads ignore the destination select.
      if (held.op == bars_pkg::BARS_OP_XORIMM) begin
        next_acc = aluOut;
      end else if (held.op == bars_pkg::BARS_OP_DIR) begin
        next_acc = acc;
      end else if (held.toReg) begin
        wrEn = 1'b1;
      end else begin
        next_acc = aluOut;
      end
      next_result = aluOut;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      acc    <= bars_pkg::ACC_RESET;
      flags  <= '0;
      result <= '0;
    end else begin
      acc    <= next_acc;
      flags  <= next_flags;
      result <= next_result;
    end
  end

  // ****************************************************************
  // Direction registers
  // ****************************************************************
  // Addresses other than the two direction registers are ignored,
  // yet the command still completes with a done pulse.
  always_comb begin
    next_pinDirLo = pinDirLo;
    next_pinDirHi = pinDirHi;
    if ((state == BARS_ST_EXEC) && (held.op == bars_pkg::BARS_OP_DIR)) begin
      if (held.addr == bars_pkg::DIR_REG_LO) begin
        next_pinDirLo = acc;
      end else if (held.addr == bars_pkg::DIR_REG_HI) begin
        next_pinDirHi = acc;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pinDirLo <= bars_pkg::DIR_RESET;
      pinDirHi <= bars_pkg::DIR_RESET;
    end else begin
      pinDirLo <= next_pinDirLo;
      pinDirHi <= next_pinDirHi;
    end
  end

endmodule

// ---- src/bars_pkg.sv ----
package bars_pkg;

  // ****************************************************************
  // Operations and widths
  // ****************************************************************
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned ADDR_W  = 5;
  localparam int unsigned REG_CNT = 32;

  localparam logic [ADDR_W-1:0] DIR_REG_LO = 5'h06;
  localparam logic [ADDR_W-1:0] DIR_REG_HI = 5'h07;

  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DIR_RESET = 8'hff;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;

  localparam int unsigned STAT_C  = 0;
  localparam int unsigned STAT_DC = 1;
  localparam int unsigned STAT_Z  = 2;

  typedef enum logic [2:0] {
    BARS_OP_NONE   = 3'h0,
    BARS_OP_RLC    = 3'h1,
    BARS_OP_RRC    = 3'h2,
    BARS_OP_SUB    = 3'h3,
    BARS_OP_SWAP   = 3'h4,
    BARS_OP_DIR    = 3'h5,
    BARS_OP_XORIMM = 3'h6,
    BARS_OP_XORREG = 3'h7
  } bars_op_type;

  typedef struct packed {
    bars_op_type             op;
    logic [ADDR_W-1:0]       addr;
    logic                    toReg;
    logic [DATA_W-1:0]       imm;
  } bars_cmd_type;

  typedef struct packed {
    logic carry;
    logic halfCarry;
    logic zero;
  } bars_flags_type;

endpackage

// ---- src/bars_regfile.sv ----
module bars_regfile (
  input  wire logic                           clk,
  input  wire logic                           reset_n,
  input  wire logic [bars_pkg::ADDR_W-1:0]    rdAddr,
  output logic      [bars_pkg::DATA_W-1:0]    rdData,
  input  wire logic                           wrEn,
  input  wire logic [bars_pkg::ADDR_W-1:0]    wrAddr,
  input  wire logic [bars_pkg::DATA_W-1:0]    wrData
);

  logic [bars_pkg::DATA_W-1:0] mem [bars_pkg::REG_CNT];
  logic [bars_pkg::DATA_W-1:0] next_rdData;

  // ****************************************************************
  // Storage with registered, write-through read
  // ****************************************************************
  always_comb begin
    next_rdData = mem[rdAddr];
    if (wrEn && (wrAddr == rdAddr)) begin
      next_rdData = wrData;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdData <= bars_pkg::REG_RESET;
    end else begin
      rdData <= next_rdData;
    end
  end

  // The array is cleared by reset as well, so an operand read before its
  // first write is a defined value and never poisons the flags.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < bars_pkg::REG_CNT; i++) begin
        mem[i] <= bars_pkg::REG_RESET;
      end
    end else if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

endmodule

// ---- verif/bars_alu_monitor.sv ----
module bars_alu_monitor (
  input wire logic                     clk,
  input wire logic                     reset_n,
  input wire logic                     cmdValid,
  input wire bars_pkg::bars_cmd_type   cmd,
  input wire logic                     busy,
  input wire logic                     done,
  input wire logic [7:0]               acc,
  input wire bars_pkg::bars_flags_type flags,
  input wire logic [7:0]               pinDirLo,
  input wire logic [7:0]               pinDirHi,
  input wire logic [7:0]               result
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Checks
  // ****
  // Operands are held at acceptance, since acc and flags move on done.
  logic                     take;
  bars_pkg::bars_cmd_type   c;
  logic [7:0]               a;
  bars_pkg::bars_flags_type f;
  assign take = cmdValid && !busy && cmd.op != bars_pkg::BARS_OP_NONE;
  always_ff @(posedge clk) begin
    if (take) begin
      c <= cmd;
      a <= acc;
      f <= flags;
    end
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence run_s;
    busy ##1 busy ##1 done && !busy;
  endsequence
  accept_done_a: assert property (take |=> run_s) else $error("done late");
  done_pulse_a: assert property (done |=> !done) else $error("done long");
  idle_stay_a: assert property (!busy && !take |=> !busy && !done) else $error("bad start");
  xor_imm_a: assert property (done && c.op == bars_pkg::BARS_OP_XORIMM |->
    acc == (a ^ c.imm) && flags.zero == (acc == 8'h00)) else $error("xor imm");
  dir_keep_a: assert property (done && c.op == bars_pkg::BARS_OP_DIR |->
    acc == a && flags == f) else $error("dir load");
  swap_keep_a: assert property (done && c.op == bars_pkg::BARS_OP_SWAP |-> flags == f) else $error("swap");
  dest_reg_a: assert property (done && c.toReg && c.op != bars_pkg::BARS_OP_XORIMM |->
    acc == a) else $error("dest reg");
  rot_keep_a: assert property (done && c.op inside {bars_pkg::BARS_OP_RLC, bars_pkg::BARS_OP_RRC} |->
    flags.halfCarry == f.halfCarry && flags.zero == f.zero) else $error("rotate");
  xor_reg_a: assert property (done && c.op == bars_pkg::BARS_OP_XORREG |->
    flags.zero == (result == 8'h00) && flags.carry == f.carry) else $error("xor reg");
endmodule

bind bars_alu bars_alu_monitor bars_alu_monitor_i (.clk, .reset_n, .cmdValid, .cmd, .busy, .done, .acc, .flags,
  .pinDirLo, .pinDirHi, .result);

// ---- verif/bars_decoder_model.sv ----
module bars_decoder_model (
  input  wire logic              clk,
  input  wire logic              done,
  output logic                   cmdValid,
  output bars_pkg::bars_cmd_type cmd
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Issue
  // ****
  initial begin
    cmdValid = 1'b0;
    cmd = '0;
  end
  task automatic issue(input bars_pkg::bars_cmd_type k, output bit late);
    @(posedge clk);
    #1;
    cmdValid = 1'b1;
    cmd = k;
    @(posedge clk);
    #1;
    cmdValid = 1'b0;
    cmd = ~k;
    late = k.op != bars_pkg::BARS_OP_NONE;
    for (int n = 0; n < 8 && late; n++) begin
      @(posedge clk);
      #1;
      late = done !== 1'b1;
    end
  endtask
  // Offers a second command during the first busy cycle; it must be ignored.
  task automatic issue_then_offer(input bars_pkg::bars_cmd_type k, input bars_pkg::bars_cmd_type extra,
                                  output bit late);
    @(posedge clk);
    #1;
    cmdValid = 1'b1;
    cmd = k;
    @(posedge clk);
    #1;
    cmd = extra;
    @(posedge clk);
    #1;
    cmdValid = 1'b0;
    cmd = ~k;
    @(posedge clk);
    #1;
    late = done !== 1'b1;
  endtask
endmodule

// ---- verif/tb.sv ----
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                     clk = 1'b0;
  logic                     reset_n = 1'b0;
  logic                     cmdValid, busy, done;
  bars_pkg::bars_cmd_type   cmd;
  logic [7:0]               acc, pinDirLo, pinDirHi, result, r;
  bars_pkg::bars_flags_type flags;
  int                       failures = 0;
  int                       tests_run = 0;
  always #5 clk = ~clk;
  bars_alu bars_alu_i (.clk, .reset_n, .cmdValid, .cmd, .busy, .done, .acc, .flags, .pinDirLo, .pinDirHi, .result);
  bars_decoder_model bars_decoder_model_i (.clk, .done, .cmdValid, .cmd);
  // ****
  // Tasks
  // ****
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic step(input bars_pkg::bars_op_type o, input logic [4:0] ad, input logic d, input logic [7:0] k,
                      input logic [7:0] er, input logic [7:0] ea, input logic [2:0] ef);
    bit late;
    bars_decoder_model_i.issue('{o, ad, d, k}, late);
    if (late) begin
      failures++;
      report_and_stop();
    end else begin
      chk("result", er, result);
      chk("acc", ea, acc);
      chk("flags", {5'h00, ef}, {5'h00, flags});
    end
  endtask
  task automatic t_dir();
    step(bars_pkg::BARS_OP_XORIMM, 5'h00, 1'b0, 8'ha5, 8'ha5, 8'ha5, 3'h0);
    step(bars_pkg::BARS_OP_DIR, 5'h06, 1'b0, 8'h00, 8'ha5, 8'ha5, 3'h0);
    step(bars_pkg::BARS_OP_XORIMM, 5'h00, 1'b0, 8'h99, 8'h3c, 8'h3c, 3'h0);
    step(bars_pkg::BARS_OP_DIR, 5'h07, 1'b0, 8'h00, 8'h3c, 8'h3c, 3'h0);
    step(bars_pkg::BARS_OP_DIR, 5'h05, 1'b0, 8'h00, 8'h3c, 8'h3c, 3'h0);
    chk("pinDirHi", 8'h3c, pinDirHi);
    chk("pinDirLo", 8'ha5, pinDirLo);
    step(bars_pkg::BARS_OP_XORIMM, 5'h00, 1'b0, 8'h3c, 8'h00, 8'h00, 3'h1);
    $display("direction and immediate test end");
  endtask
  task automatic t_regs();
    step(bars_pkg::BARS_OP_XORREG, 5'h1f, 1'b0, 8'h00, 8'h00, 8'h00, 3'h1);
    r = acc;
    step(bars_pkg::BARS_OP_SUB, 5'h1f, 1'b1, 8'h00, 8'h00, r, 3'h7);
    step(bars_pkg::BARS_OP_XORIMM, 5'h00, 1'b0, r ^ 8'h96, 8'h96, 8'h96, 3'h6);
    step(bars_pkg::BARS_OP_XORREG, 5'h1f, 1'b1, 8'h00, 8'h96, 8'h96, 3'h6);
    step(bars_pkg::BARS_OP_RLC, 5'h1f, 1'b0, 8'h00, 8'h2d, 8'h2d, 3'h6);
    step(bars_pkg::BARS_OP_RRC, 5'h1f, 1'b1, 8'h00, 8'hcb, 8'h2d, 3'h2);
    step(bars_pkg::BARS_OP_SWAP, 5'h1f, 1'b0, 8'h00, 8'hbc, 8'hbc, 3'h2);
    step(bars_pkg::BARS_OP_SUB, 5'h1f, 1'b0, 8'h00, 8'h0f, 8'h0f, 3'h4);
    step(bars_pkg::BARS_OP_XORIMM, 5'h00, 1'b0, 8'hf0, 8'hff, 8'hff, 3'h4);
    step(bars_pkg::BARS_OP_SUB, 5'h1f, 1'b0, 8'h00, 8'hcc, 8'hcc, 3'h0);
    step(bars_pkg::BARS_OP_NONE, 5'h1f, 1'b0, 8'h00, 8'hcc, 8'hcc, 3'h0);
    $display("file register test end");
  endtask
  task automatic t_refuse();
    bit late;
    bars_decoder_model_i.issue_then_offer('{bars_pkg::BARS_OP_XORIMM, 5'h00, 1'b0, 8'h0f},
                                          '{bars_pkg::BARS_OP_XORIMM, 5'h00, 1'b0, 8'hff}, late);
    if (late) begin
      failures++;
      report_and_stop();
    end else begin
      chk("acc", 8'hc3, acc);
      repeat (3) @(posedge clk);
      #1;
      chk("acc", 8'hc3, acc);
      chk("done", 8'h00, {7'h00, done});
      $display("refused command test end");
    end
  endtask
  task automatic t_reset();
    @(posedge clk);
    #1 reset_n = 1'b0;
    @(posedge clk);
    #1;
    chk("acc", 8'h00, acc);
    chk("result", 8'h00, result);
    chk("flags", 8'h00, {5'h00, flags});
    chk("pinDirLo", 8'hff, pinDirLo);
    chk("pinDirHi", 8'hff, pinDirHi);
    @(posedge clk);
    #1 reset_n = 1'b1;
    step(bars_pkg::BARS_OP_XORREG, 5'h1f, 1'b0, 8'h00, 8'h00, 8'h00, 3'h1);
    $display("mid-run reset test end");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    #1 reset_n = 1'b1;
    chk("pinDirLo", 8'hff, pinDirLo);
    t_dir();
    t_regs();
    t_refuse();
    t_reset();
    report_and_stop();
  end
endmodule
